// *** include/cst_pkg.sv ***
// Constants shared by the cyclic sense timers and switch shutdown block
package cst_pkg;

  // Time base
  localparam int unsigned CST_CLK_HZ     = 25_000_000;
  localparam int unsigned CST_CYC_PER_US = CST_CLK_HZ / 1_000_000;
  localparam int          CST_CW         = 26;

  // Period choices in microseconds, codes 000..110
  localparam int unsigned CST_PER0_US = 10_000;
  localparam int unsigned CST_PER1_US = 20_000;
  localparam int unsigned CST_PER2_US = 50_000;
  localparam int unsigned CST_PER3_US = 100_000;
  localparam int unsigned CST_PER4_US = 200_000;
  localparam int unsigned CST_PER5_US = 1_000_000;
  localparam int unsigned CST_PER6_US = 2_000_000;

  // On-time choices in microseconds, codes 001..101
  localparam int unsigned CST_ON1_US = 100;
  localparam int unsigned CST_ON2_US = 300;
  localparam int unsigned CST_ON3_US = 1_000;
  localparam int unsigned CST_ON4_US = 10_000;
  localparam int unsigned CST_ON5_US = 20_000;

  // Cycle counts derived from the times, index = period code
  localparam logic [6:0][CST_CW-1:0] CST_PERIOD_CYC_DEF = {
    CST_CW'(CST_PER6_US * CST_CYC_PER_US),
    CST_CW'(CST_PER5_US * CST_CYC_PER_US),
    CST_CW'(CST_PER4_US * CST_CYC_PER_US),
    CST_CW'(CST_PER3_US * CST_CYC_PER_US),
    CST_CW'(CST_PER2_US * CST_CYC_PER_US),
    CST_CW'(CST_PER1_US * CST_CYC_PER_US),
    CST_CW'(CST_PER0_US * CST_CYC_PER_US)};

  // Index = on-time code minus one
  localparam logic [4:0][CST_CW-1:0] CST_ONTIME_CYC_DEF = {
    CST_CW'(CST_ON5_US * CST_CYC_PER_US),
    CST_CW'(CST_ON4_US * CST_CYC_PER_US),
    CST_CW'(CST_ON3_US * CST_CYC_PER_US),
    CST_CW'(CST_ON2_US * CST_CYC_PER_US),
    CST_CW'(CST_ON1_US * CST_CYC_PER_US)};

  // Wake sampling filter at the end of the on-time
  localparam int unsigned   CST_FILT_US  = 16;
  localparam logic [CST_CW-1:0] CST_FILT_CYC =
    CST_CW'(CST_FILT_US * CST_CYC_PER_US);

  // Register word indices; byte address is four times the index
  localparam logic [5:0] CST_IDX_TIMER_ONE = 6'h0c;
  localparam logic [5:0] CST_IDX_TIMER_TWO = 6'h0d;
  localparam logic [5:0] CST_IDX_SHUTDOWN  = 6'h10;
  localparam logic [5:0] CST_IDX_STATUS    = 6'h11;

  // Field positions
  localparam int CST_ON_LSB     = 4;
  localparam int CST_PER_LSB    = 0;
  localparam int CST_OV_DIS_BIT = 6;
  localparam int CST_UV_DIS_BIT = 5;
  localparam int CST_REC_BIT    = 4;

  // Reset values
  localparam logic [2:0] CST_CODE_RST = 3'h0;
  localparam logic [2:0] CST_SD_RST   = 3'h0;

  // On-time codes and the highest period code
  localparam logic [2:0] CST_ON_OFF_LOW  = 3'h0;
  localparam logic [2:0] CST_ON_RUN_MIN  = 3'h1;
  localparam logic [2:0] CST_ON_RUN_MAX  = 3'h5;
  localparam logic [2:0] CST_ON_OFF_HIGH = 3'h6;
  localparam logic [2:0] CST_PER_MAX     = 3'h6;

  // High-side switch configuration codes
  localparam logic [2:0] CST_HS_OFF  = 3'h0;
  localparam logic [2:0] CST_HS_ON   = 3'h1;
  localparam logic [2:0] CST_HS_TMR1 = 3'h2;
  localparam logic [2:0] CST_HS_TMR2 = 3'h3;
  localparam logic [2:0] CST_HS_PWM1 = 3'h4;
  localparam logic [2:0] CST_HS_PWM2 = 3'h5;

  // Wake filter configuration codes for cyclic sensing
  localparam logic [1:0] CST_WK_CYC_TMR1 = 2'h2;
  localparam logic [1:0] CST_WK_CYC_TMR2 = 2'h3;

endpackage

// *** hdl/cst_cyclic_timer.sv ***
// One cyclic timer: period and on-time sequencer
`timescale 1ns/100ps
`default_nettype none
module cst_cyclic_timer
  import cst_pkg::*;
#(
  parameter logic [6:0][CST_CW-1:0] PERIOD_CYC = CST_PERIOD_CYC_DEF,
  parameter logic [4:0][CST_CW-1:0] ONTIME_CYC = CST_ONTIME_CYC_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] on_code,
  input  wire logic [2:0] per_code,
  output logic            level,
  output logic            tail,
  output logic            on_end,
  output logic            per_end,
  output logic            running
);

  logic [2:0]        act_on_q;
  logic [2:0]        act_per_q;
  logic [CST_CW-1:0] cnt_q;
  logic [CST_CW-1:0] on_cyc;
  logic [CST_CW-1:0] per_cyc;
  logic              new_run;

  // Decode of the active codes into cycle counts
  always_comb begin
    if (act_on_q >= CST_ON_RUN_MIN && act_on_q <= CST_ON_RUN_MAX) begin
      on_cyc = ONTIME_CYC[3'(act_on_q - CST_ON_RUN_MIN)];
    end else begin
      on_cyc = '0;
    end
    if (act_per_q <= CST_PER_MAX) begin
      per_cyc = PERIOD_CYC[act_per_q];
    end else begin
      per_cyc = PERIOD_CYC[CST_PER_MAX];
    end
  end

  assign running = act_on_q >= CST_ON_RUN_MIN && act_on_q <= CST_ON_RUN_MAX;
  assign new_run = on_code >= CST_ON_RUN_MIN && on_code <= CST_ON_RUN_MAX;
  assign per_end = running && cnt_q == per_cyc - 1'b1;
  assign on_end  = running && cnt_q == on_cyc - 1'b1;

  // Active on the first part of each period; stop codes hold a level
  assign level = running ? (cnt_q < on_cyc)
                         : (act_on_q == CST_ON_OFF_HIGH);

  // Last filter window of the on-time
  assign tail = running && cnt_q < on_cyc &&
                (on_cyc <= CST_FILT_CYC || cnt_q >= on_cyc - CST_FILT_CYC);

  // Stop and start apply at once, running changes at the boundary
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_on_q  <= CST_CODE_RST;
      act_per_q <= CST_CODE_RST;
      cnt_q     <= '0;
    end else if (!new_run || !running) begin
      act_on_q  <= on_code;
      act_per_q <= per_code;
      cnt_q     <= '0;
    end else if (per_end) begin
      act_on_q  <= on_code;
      act_per_q <= per_code;
      cnt_q     <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  AST_ON_END: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(level) && running |-> $past(cnt_q) == on_cyc - 1'b1)
    else $error("on-time ended at the wrong count");

  AST_PERIOD_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    per_end && new_run |=> cnt_q == '0 && running)
    else $error("period did not wrap at its end");

  AST_START_ACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
    running && cnt_q == '0 |-> level)
    else $error("output not active at period start");

  AST_NO_GLITCH: assert property (@(posedge clk) disable iff (!rst_n)
    running && $past(running) && cnt_q != '0
      |-> $stable(act_on_q) && $stable(act_per_q))
    else $error("timer setting changed inside a period");

endmodule // cst_cyclic_timer
`default_nettype wire

// *** hdl/cst_top.sv ***
// Cyclic sense timers and high-side switch supply fault shutdown
`timescale 1ns/100ps
`default_nettype none
// Function
// - On code 000 stops timer, output low
// - On codes 001-101 give five on-times
// - On code 110 stops timer, output high
// - Period codes 000-110 give seven periods
// - Running on-time write starts assigned timer
// - Restart switch clear with sensing clears timers
// - Cyclic sensing and wake run together
// - Timer registers cleared by resets, restart
// - Shutdown register keeps bits 6:4 on restart
// - Bit 6 low: overvoltage turns switches off
// - Bit 5 low: undervoltage turns switches off
// - Bit 4 restores switches after fault
// - Reserved bits read as zero
// - Switch codes 010/011 select timer one/two
// - Wake sampled with filter at on-time end
module cst_top
  import cst_pkg::*;
#(
  parameter logic [6:0][CST_CW-1:0] PERIOD_CYC = CST_PERIOD_CYC_DEF,
  parameter logic [4:0][CST_CW-1:0] ONTIME_CYC = CST_ONTIME_CYC_DEF
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SOFT_RESET,
  input  wire logic        RESTART_ENTRY,
  input  wire logic        RESTART_MODE,
  input  wire logic        HS_CTRL_CLEAR,
  input  wire logic [11:0] HS_CONFIG,
  input  wire logic [1:0]  PWM_IN,
  input  wire logic        SUPPLY_OV,
  input  wire logic        SUPPLY_UV,
  input  wire logic        WAKE_IN,
  input  wire logic [1:0]  WAKE_FLT_CFG,
  input  wire logic [1:0]  TIMER_WAKE_EN,
  output logic      [3:0]  HS_OUT,
  output logic             WAKE_DETECT,
  output logic      [1:0]  TIMER_WAKE
);

  logic [2:0]  t1_on_q, t1_per_q, t2_on_q, t2_per_q;
  logic [2:0]  sd_q;
  logic [11:0] hs_cfg_q;
  logic [3:0]  lat_q;
  logic [3:0]  hs_d;
  logic        filt_ok_q, tail_prev_q;
  logic [1:0]  lvl, tail, on_end, per_end, run;
  logic        apb_acc, wr_acc;
  logic [5:0]  idx;
  logic        mapped;
  logic        timer_clr;
  logic        fault;
  logic        cyc_sel;
  logic        sel_tail, sel_end;
  logic [7:0]  rd_byte;

  // Bus access decode; answer comes one cycle into the access phase
  assign idx     = PADDR[7:2];
  assign apb_acc = PSEL && PENABLE && PREADY;
  assign wr_acc  = apb_acc && PWRITE && !PSLVERR;
  assign mapped  = idx == CST_IDX_TIMER_ONE || idx == CST_IDX_TIMER_TWO ||
                   idx == CST_IDX_SHUTDOWN || idx == CST_IDX_STATUS;

  // Timer clear on soft reset, restart entry or restart switch clear
  assign cyc_sel   = WAKE_FLT_CFG[1];
  assign timer_clr = SOFT_RESET || RESTART_ENTRY ||
                     (RESTART_MODE && HS_CTRL_CLEAR && cyc_sel);

  // Timer control registers
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      t1_on_q  <= CST_CODE_RST;
      t1_per_q <= CST_CODE_RST;
      t2_on_q  <= CST_CODE_RST;
      t2_per_q <= CST_CODE_RST;
    end else if (timer_clr) begin
      t1_on_q  <= CST_CODE_RST;
      t1_per_q <= CST_CODE_RST;
      t2_on_q  <= CST_CODE_RST;
      t2_per_q <= CST_CODE_RST;
    end else if (wr_acc && idx == CST_IDX_TIMER_ONE) begin
      t1_on_q  <= PWDATA[CST_ON_LSB +: 3];
      t1_per_q <= PWDATA[CST_PER_LSB +: 3];
    end else if (wr_acc && idx == CST_IDX_TIMER_TWO) begin
      t2_on_q  <= PWDATA[CST_ON_LSB +: 3];
      t2_per_q <= PWDATA[CST_PER_LSB +: 3];
    end
  end

  // Shutdown control; restart leaves the three control bits alone
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sd_q <= CST_SD_RST;
    end else if (SOFT_RESET) begin
      sd_q <= CST_SD_RST;
    end else if (wr_acc && idx == CST_IDX_SHUTDOWN) begin
      sd_q <= PWDATA[CST_REC_BIT +: 3];
    end
  end

  // Read data; reserved bits stay zero
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      CST_IDX_TIMER_ONE: begin
        rd_byte[CST_ON_LSB +: 3]  = t1_on_q;
        rd_byte[CST_PER_LSB +: 3] = t1_per_q;
      end
      CST_IDX_TIMER_TWO: begin
        rd_byte[CST_ON_LSB +: 3]  = t2_on_q;
        rd_byte[CST_PER_LSB +: 3] = t2_per_q;
      end
      CST_IDX_SHUTDOWN: begin
        rd_byte[CST_REC_BIT +: 3] = sd_q;
      end
      CST_IDX_STATUS: begin
        rd_byte = {HS_OUT, |lat_q, fault, run};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Bus answer registers
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
      if (PSEL && PENABLE && !PREADY && !PWRITE) begin
        PRDATA <= {24'h00_0000, rd_byte};
      end
    end
  end

  // The two timers
  cst_cyclic_timer #(
    .PERIOD_CYC (PERIOD_CYC),
    .ONTIME_CYC (ONTIME_CYC)
  ) u_timer_one (
    .clk      (REF_CLK),
    .rst_n    (RESET_N),
    .on_code  (t1_on_q),
    .per_code (t1_per_q),
    .level    (lvl[0]),
    .tail     (tail[0]),
    .on_end   (on_end[0]),
    .per_end  (per_end[0]),
    .running  (run[0])
  );

  cst_cyclic_timer #(
    .PERIOD_CYC (PERIOD_CYC),
    .ONTIME_CYC (ONTIME_CYC)
  ) u_timer_two (
    .clk      (REF_CLK),
    .rst_n    (RESET_N),
    .on_code  (t2_on_q),
    .per_code (t2_per_q),
    .level    (lvl[1]),
    .tail     (tail[1]),
    .on_end   (on_end[1]),
    .per_end  (per_end[1]),
    .running  (run[1])
  );

  // Supply fault unless its shutdown is disabled
  assign fault = (SUPPLY_OV && !sd_q[CST_OV_DIS_BIT - CST_REC_BIT]) ||
                 (SUPPLY_UV && !sd_q[CST_UV_DIS_BIT - CST_REC_BIT]);

  // Switch source selection and fault gating, one per switch
  for (genvar i = 0; i < 4; i++) begin : g_hs
    logic [2:0] cfg;
    logic       src;
    assign cfg = HS_CONFIG[3*i +: 3];
    always_comb begin
      case (cfg)
        CST_HS_OFF:  src = 1'b0;
        CST_HS_ON:   src = 1'b1;
        CST_HS_TMR1: src = lvl[0];
        CST_HS_TMR2: src = lvl[1];
        CST_HS_PWM1: src = PWM_IN[0];
        CST_HS_PWM2: src = PWM_IN[1];
        default:     src = 1'b0;
      endcase
      hs_d[i] = src && !fault && !lat_q[i];
    end

    // Without recovery a fault latches the switch off until reconfigured
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        lat_q[i] <= 1'b0;
      end else if (fault && !sd_q[CST_REC_BIT - CST_REC_BIT] && src) begin
        lat_q[i] <= 1'b1;
      end else if (HS_CONFIG[3*i +: 3] != hs_cfg_q[3*i +: 3]) begin
        lat_q[i] <= 1'b0;
      end
    end
  end

  // Configuration history and switch outputs
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hs_cfg_q <= 12'h000;
      HS_OUT   <= 4'h0;
    end else begin
      hs_cfg_q <= HS_CONFIG;
      HS_OUT   <= hs_d;
    end
  end

  // Wake input filtered over the last window of the selected on-time
  assign sel_tail = WAKE_FLT_CFG == CST_WK_CYC_TMR1 ? tail[0] :
                    WAKE_FLT_CFG == CST_WK_CYC_TMR2 ? tail[1] : 1'b0;
  assign sel_end  = WAKE_FLT_CFG == CST_WK_CYC_TMR1 ? on_end[0] :
                    WAKE_FLT_CFG == CST_WK_CYC_TMR2 ? on_end[1] : 1'b0;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tail_prev_q <= 1'b0;
      filt_ok_q   <= 1'b0;
      WAKE_DETECT <= 1'b0;
    end else begin
      tail_prev_q <= sel_tail;
      if (sel_tail && !tail_prev_q) begin
        filt_ok_q <= WAKE_IN;
      end else if (sel_tail) begin
        filt_ok_q <= filt_ok_q && WAKE_IN;
      end
      WAKE_DETECT <= sel_end && tail_prev_q && filt_ok_q && WAKE_IN;
    end
  end

  // Cyclic wake from the same timers, alongside sensing
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TIMER_WAKE <= 2'h0;
    end else begin
      TIMER_WAKE <= per_end & TIMER_WAKE_EN;
    end
  end

  AST_STOP_LOW: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    (HS_CONFIG[2:0] == CST_HS_TMR1 && t1_on_q == CST_ON_OFF_LOW)[*3]
      |-> !HS_OUT[0])
    else $error("switch on a stopped low timer not low");

  AST_STOP_HIGH: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    (HS_CONFIG[2:0] == CST_HS_TMR1 && t1_on_q == CST_ON_OFF_HIGH &&
     !fault && !lat_q[0])[*3] |-> HS_OUT[0])
    else $error("switch on a stopped high timer not high");

  AST_AUTO_START: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    wr_acc && idx == CST_IDX_TIMER_ONE && !run[0] &&
    PWDATA[CST_ON_LSB +: 3] >= CST_ON_RUN_MIN &&
    PWDATA[CST_ON_LSB +: 3] <= CST_ON_RUN_MAX &&
    !timer_clr ##1 !timer_clr |=> run[0])
    else $error("timer did not start after a running code");

  AST_RESTART_CLEAR: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    RESTART_ENTRY |=> t1_on_q == '0 && t1_per_q == '0 &&
                      t2_on_q == '0 && t2_per_q == '0)
    else $error("timer registers not cleared on restart");

  AST_RESTART_KEEP: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    RESTART_ENTRY && !SOFT_RESET && !wr_acc |=> $stable(sd_q))
    else $error("shutdown control lost on restart");

  AST_OV_OFF: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    SUPPLY_OV && !sd_q[CST_OV_DIS_BIT - CST_REC_BIT] |=> HS_OUT == '0)
    else $error("switches on during overvoltage");

  AST_UV_OFF: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    SUPPLY_UV && !sd_q[CST_UV_DIS_BIT - CST_REC_BIT] |=> HS_OUT == '0)
    else $error("switches on during undervoltage");

  AST_NO_RECOVER: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    fault && !sd_q[CST_REC_BIT - CST_REC_BIT] && HS_OUT[0]
      ##1 $stable(HS_CONFIG) |=> !HS_OUT[0])
    else $error("switch recovered with recovery disabled");

  AST_RSVD_ZERO: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    PREADY && !PWRITE && PSEL && idx != CST_IDX_STATUS
      |-> PRDATA[31:8] == '0 && !PRDATA[7] && !PRDATA[3] &&
          (idx != CST_IDX_SHUTDOWN || PRDATA[2:0] == '0))
    else $error("reserved bits read non-zero");

  AST_WAKE_WINDOW: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    WAKE_DETECT |-> $past(WAKE_IN) && $past(tail_prev_q))
    else $error("wake detected outside the on-time window");

  AST_TMR1_MAP: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    HS_CONFIG[2:0] == CST_HS_TMR1 && !fault && !lat_q[0]
      |=> HS_OUT[0] == $past(lvl[0]))
    else $error("switch one not following timer one");

  AST_TMR2_MAP: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    HS_CONFIG[5:3] == CST_HS_TMR2 && !fault && !lat_q[1]
      |=> HS_OUT[1] == $past(lvl[1]))
    else $error("switch two not following timer two");

  AST_OV_KEEP: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    SUPPLY_OV && !SUPPLY_UV && sd_q[CST_OV_DIS_BIT - CST_REC_BIT] &&
    HS_CONFIG[8:6] == CST_HS_ON && !lat_q[2] |=> HS_OUT[2])
    else $error("switch off on overvoltage with shutdown disabled");

  AST_UV_KEEP: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    SUPPLY_UV && !SUPPLY_OV && sd_q[CST_UV_DIS_BIT - CST_REC_BIT] &&
    HS_CONFIG[8:6] == CST_HS_ON && !lat_q[2] |=> HS_OUT[2])
    else $error("switch off on undervoltage with shutdown disabled");

  AST_TIMER_WAKE: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    per_end[0] && TIMER_WAKE_EN[0] |=> TIMER_WAKE[0])
    else $error("cyclic wake missing at period end");

endmodule // cst_top
`default_nettype wire

// *** tb/cst_wake_contact.sv ***
// Wake contact model: a sense contact fed by one high-side switch
`timescale 1ns/100ps
`default_nettype none
module cst_wake_contact (
  input  wire logic       closed,
  input  wire logic [3:0] hs_out,
  input  wire logic [1:0] feed_sel,
  output logic            wake_in
);
  // Closed contact passes the switch level; open contact sees a pull-down
  assign wake_in = closed & hs_out[feed_sel];
endmodule // cst_wake_contact
`default_nettype wire

// *** tb/cst_top_tb_top.sv ***
// Self-checking bench for the cyclic sense timers and shutdown block
`timescale 1ns/100ps
`default_nettype none
module cst_top_tb_top;
  import cst_pkg::*;
  // Shortened periods and on-times keep the run short
  localparam logic [6:0][CST_CW-1:0] PER = {26'ha8c, 26'h9c4, 26'h8fc,
    26'h834, 26'h76c, 26'h6a4, 26'h5dc};
  localparam logic [4:0][CST_CW-1:0] ONT = {26'h514, 26'h44c, 26'h384,
    26'h2bc, 26'h1f4};
  localparam logic [5:0] I1 = CST_IDX_TIMER_ONE;
  localparam logic [5:0] I2 = CST_IDX_TIMER_TWO;
  localparam logic [5:0] SD = CST_IDX_SHUTDOWN;

  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  logic        soft_reset = 1'b0, restart_entry = 1'b0;
  logic        restart_mode = 1'b0, hs_ctrl_clear = 1'b0;
  logic [11:0] hs_config = 12'h000;
  logic        supply_ov = 1'b0, supply_uv = 1'b0, closed = 1'b0;
  logic        wake_in, wake_detect;
  logic [1:0]  wake_flt_cfg = 2'h0, timer_wake_en = 2'h0, timer_wake;
  logic [3:0]  hs_out;
  logic [31:0] rnd_q = 32'h6dab;
  int          failures = 0, cmp_count = 0, cyc = 0;

  cst_top #(.PERIOD_CYC(PER), .ONTIME_CYC(ONT)) uut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SOFT_RESET(soft_reset),
    .RESTART_ENTRY(restart_entry), .RESTART_MODE(restart_mode),
    .HS_CTRL_CLEAR(hs_ctrl_clear), .HS_CONFIG(hs_config),
    .PWM_IN(2'b00), .SUPPLY_OV(supply_ov), .SUPPLY_UV(supply_uv),
    .WAKE_IN(wake_in), .WAKE_FLT_CFG(wake_flt_cfg),
    .TIMER_WAKE_EN(timer_wake_en), .HS_OUT(hs_out),
    .WAKE_DETECT(wake_detect), .TIMER_WAKE(timer_wake));

  cst_wake_contact contact (.closed(closed), .hs_out(hs_out),
    .feed_sel(2'b00), .wake_in(wake_in));

  // Clock and hang guard
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      summarize();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Read-back value: reserved bits drop out
  function automatic logic [7:0] exp_reg(input logic [5:0] i,
                                          input logic [7:0] d);
    return (i == SD) ? (d & 8'h70) : (d & 8'h77);
  endfunction

  task automatic summarize();
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask

  // One APB transfer, held until PREADY is sampled high
  task automatic apb(input logic wr, input logic [5:0] idx,
                     input logic [7:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready wait", 32'h1, 32'(n < 20));
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, idx, d, rd, er);
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, idx, 8'h00, rd, er);
    chk("register", {24'h0, e}, rd);
  endtask

  task automatic wait_lvl(input int sw, input logic v, output int n);
    n = 0;
    while (hs_out[sw] !== v && n < 6000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  // One-cycle pulse: 0 restart entry, 1 switch clear, else soft reset
  task automatic pulse(input int w);
    @(posedge ref_clk);
    case (w)
      0: restart_entry <= 1'b1;
      1: hs_ctrl_clear <= 1'b1;
      default: soft_reset <= 1'b1;
    endcase
    @(posedge ref_clk);
    restart_entry <= 1'b0;
    hs_ctrl_clear <= 1'b0;
    soft_reset <= 1'b0;
  endtask

  // Count highs of one switch, wake detects and timer wakes
  task automatic count(input int sw, input int len, output int h,
                       output int wd, output int tw0, output int tw1);
    h = 0;
    wd = 0;
    tw0 = 0;
    tw1 = 0;
    repeat (len) begin
      @(posedge ref_clk);
      h += int'(hs_out[sw] === 1'b1);
      wd += int'(wake_detect === 1'b1);
      tw0 += int'(timer_wake[0] === 1'b1);
      tw1 += int'(timer_wake[1] === 1'b1);
    end
  endtask

  initial begin
    logic [7:0]  d;
    logic [5:0]  idx;
    logic [31:0] rd;
    logic        er;
    int          n, w, h, wd, t0, t1, f, dis, rec;
    logic [2:0]  oc, pc;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Reset values and reserved bits under random writes
    rchk(I1, 8'h00);
    rchk(I2, 8'h00);
    rchk(SD, 8'h00);
    repeat (8) begin
      rnd_q = xs(rnd_q);
      d = rnd_q[7:0];
      if (d[6:4] == 3'h7) d[6] = 1'b0;
      if (d[2:0] == 3'h7) d[2] = 1'b0;
      idx = (rnd_q[9:8] == 2'h0) ? I1 : (rnd_q[9:8] == 2'h1) ? I2 : SD;
      wr(idx, d);
      rchk(idx, exp_reg(idx, d));
    end
    // Unmapped place is refused
    apb(1'b1, 6'h3f, 8'hff, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    // Restart entry clears timers, keeps shutdown bits 6:4
    wr(I1, 8'h15);
    wr(I2, 8'h23);
    wr(SD, 8'h70);
    pulse(0);
    rchk(I1, 8'h00);
    rchk(I2, 8'h00);
    rchk(SD, 8'h70);
    // Switch clear in restart mode, sensing off then on
    wr(I1, 8'h15);
    restart_mode <= 1'b1;
    pulse(1);
    rchk(I1, 8'h15);
    wake_flt_cfg <= 2'h2;
    pulse(1);
    restart_mode <= 1'b0;
    rchk(I1, 8'h00);
    wr(I2, 8'h23);
    pulse(2);
    rchk(I2, 8'h00);
    rchk(SD, 8'h00);
    // Assign first, then on-time start; all period codes, both timers
    hs_config <= 12'h05a;
    for (int i = 0; i < 7; i++) begin
      oc = 3'(i % 5 + 1);
      pc = 3'(i);
      wr((i % 2 == 0) ? I1 : I2, {1'b0, oc, 1'b0, pc});
      wait_lvl(i % 2, 1'b0, n);
      wait_lvl(i % 2, 1'b1, n);
      wait_lvl(i % 2, 1'b0, n);
      wait_lvl(i % 2, 1'b1, n);
      wait_lvl(i % 2, 1'b0, w);
      wait_lvl(i % 2, 1'b1, n);
      chk("on width", 32'(ONT[oc - 1]), 32'(w));
      chk("period", 32'(PER[pc]), 32'(w + n));
    end
    // Stop codes hold the output low or high
    wr(I1, 8'h00);
    repeat (4) @(posedge ref_clk);
    count(0, 2000, h, wd, t0, t1);
    chk("stop low", 32'h0, 32'(h));
    wr(I1, 8'h60);
    repeat (4) @(posedge ref_clk);
    count(0, 2000, h, wd, t0, t1);
    chk("stop high", 32'd2000, 32'(h));
    // Supply faults on an always-on switch, each fault with every setting of its disable bit and bit 4
    for (int k = 0; k < 8; k++) begin
      f = k % 2;
      dis = (k / 2) % 2;
      rec = k / 4;
      wr(SD, 8'(dis << (f ? 5 : 6)) | 8'(rec << 4));
      @(posedge ref_clk);
      if (f) supply_uv <= 1'b1;
      else supply_ov <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("fault drive", 32'(dis), {31'h0, hs_out[2]});
      supply_uv <= 1'b0;
      supply_ov <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk("after fault", 32'(dis | rec), {31'h0, hs_out[2]});
      hs_config <= 12'h000;
      repeat (3) @(posedge ref_clk);
      hs_config <= 12'h05a;
    end
    // Cyclic sensing and cyclic wake from the same timer
    wake_flt_cfg <= 2'h2;
    timer_wake_en <= 2'b01;
    closed <= 1'b1;
    wr(I1, 8'h10);
    wait_lvl(0, 1'b1, n);
    wait_lvl(0, 1'b0, n);
    count(0, 3000, h, wd, t0, t1);
    chk("wake detect", 32'd2, 32'(wd));
    chk("timer wake", 32'd2, 32'(t0));
    chk("timer two wake", 32'd0, 32'(t1));
    closed <= 1'b0;
    count(0, 3000, h, wd, t0, t1);
    chk("open contact", 32'd0, 32'(wd));
    chk("wake w/o sense", 32'd2, 32'(t0));
    summarize();
  end
endmodule // cst_top_tb_top
`default_nettype wire
